// *** dv/brs_properties.sv ***
/*
  brs_properties: port-level checks on brs_top, bound below.
  assumes: one pclk domain, presetn async active low.
*/
`timescale 1ns/100ps
`default_nettype none
module brs_properties
  import brs_pkg::*;
(
  input wire logic                  pclk,          // system clock
  input wire logic                  presetn,       // async reset
  input wire brs_pkg::brs_cfg_t     cfg,           // config bits
  input wire brs_pkg::brs_analog_t  ana,           // monitor levels
  input wire brs_pkg::brs_src_t     src,           // reset sources
  input wire logic                  sleep,         // core asleep
  input wire logic                  bor_enable,    // comparator on
  input wire logic                  level_select,  // threshold select
  input wire logic                  core_reset_n,  // core reset
  input wire logic                  run_enable     // core may run
);
  logic [5:0] low_q;  // cycles of live under-threshold
  logic [3:0] hi_q;   // cycles clear pin high
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // helper counters, saturating so long holds never wrap
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_q <= 6'h00;
    else if (!((cfg.mode_select == MODE_ON && ana.bor_ready &&
      ana.below_thresh) || (cfg.lp_enable && ana.lp_below))) low_q <= 6'h00;
    else if (low_q != 6'h3f) low_q <= low_q + 6'h01;
  end
  // pin release age, bounds the start-up tail
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_q <= 4'h0;
    else if (!src.clear_pin_n) hi_q <= 4'h0;
    else if (hi_q != 4'hf) hi_q <= hi_q + 4'h1;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_LEVEL: assert property (level_select == cfg.level_select)
    else $error("level select not passed through");
  AST_POR_HOLD: assert property (!ana.supply_ok [*4] |-> !core_reset_n)
    else $error("core ran with supply below power-on level");
  // six cycles: two sync stages, sequencer, two release flops, then one sampling edge
  AST_SRC_RESET: assert property ((|src[4:0]) [*6] |-> !core_reset_n)
    else $error("reset source did not reset core");
  AST_CLEAR_HOLD: assert property (!src.clear_pin_n [*6] |-> !core_reset_n)
    else $error("clear pin low did not reset core");
  AST_BOR_HOLD: assert property (low_q >= 6'h20 |-> !core_reset_n)
    else $error("core ran through a long brownout");
  AST_TAIL_GAP: assert property ($rose(run_enable) |-> hi_q >= 4'ha)
    else $error("run began too soon after pin release");
  AST_MODE_OFF: assert property (cfg.mode_select == MODE_OFF |-> !bor_enable)
    else $error("comparator on in off mode");
  AST_MODE_ON: assert property (cfg.mode_select == MODE_ON |-> bor_enable)
    else $error("comparator off in always-on mode");
  AST_NOSLEEP: assert property (cfg.mode_select == MODE_NOSLEEP |->
    bor_enable == !sleep)
    else $error("awake-only mode enable wrong");
endmodule : brs_properties
bind brs_top brs_properties u_brs_properties (.pclk(pclk), .presetn(presetn),
  .cfg(cfg), .ana(ana), .src(src), .sleep(sleep), .bor_enable(bor_enable),
  .level_select(level_select), .core_reset_n(core_reset_n),
  .run_enable(run_enable));
`default_nettype wire

// *** dv/brs_supply_model.sv ***
/*
  brs_supply_model: behavioural supply comparators at the far side.
  assumes: vdd is a level code the bench moves on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module brs_supply_model
  import brs_pkg::*;
#(
  parameter logic [7:0]  POR_LVL  = 8'h20,  // power-on trip code
  parameter logic [7:0]  THR_HI   = 8'h60,  // brownout trip, high
  parameter logic [7:0]  THR_LO   = 8'h50,  // brownout trip, low
  parameter logic [7:0]  LP_LVL   = 8'h40,  // low-power trip code
  parameter int unsigned RDY_FAST = 2,      // prompt settle cycles
  parameter int unsigned RDY_SLOW = 40      // slow settle cycles
) (
  input  wire logic       pclk,     // system clock
  input  wire logic [7:0] vdd,      // supply level code
  input  wire logic       lvl_sel,  // threshold select
  input  wire logic       bor_on,   // comparator powered
  input  wire logic       lp_on,    // low-power monitor on
  input  wire logic       slow,     // slow settling
  output brs_pkg::brs_analog_t ana  // monitor levels
);
  logic [7:0] rdy_q = 8'h00;
  logic       tgl_q = 1'b0;
  // settle timer restarts each time the comparator powers up
  always_ff @(posedge pclk) begin
    tgl_q <= ~tgl_q;
    if (!bor_on) rdy_q <= 8'h00;
    else if (rdy_q != 8'hff) rdy_q <= rdy_q + 8'h01;
  end
  // unpowered below_thresh and lp_below toggle, so no stale level can be trusted
  assign ana = '{supply_ok: vdd >= POR_LVL,
    below_thresh: bor_on ? vdd < (lvl_sel ? THR_LO : THR_HI) : tgl_q,
    bor_ready: bor_on && rdy_q >= (slow ? RDY_SLOW : RDY_FAST),
    lp_below: lp_on ? vdd < LP_LVL : tgl_q};
endmodule : brs_supply_model
`default_nettype wire

// *** dv/brs_top_tb.sv ***
/*
  brs_top_tb: self-checking bench for the brownout reset sequencer.
  assumes: brs_supply_model stands in for the analog monitors.
*/
`timescale 1ns/100ps
`default_nettype none
module brs_top_tb;
  import brs_pkg::*;
  localparam int unsigned PLEN = 50;  // shortened power-up delay
  logic        pclk = 1'b0, presetn = 1'b0, sleep = 1'b0, slow = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er;
  logic        bor_enable, level_select, core_reset_n, run_enable;
  brs_cfg_t    cfg = {MODE_ON, 1'b1, 1'b1, 1'b0};
  brs_analog_t ana;
  brs_src_t    src = 6'h20;  // clear pin pulled high
  logic [7:0]  vdd = 8'h70;
  int          c, n, mismatches = 0, num_checks = 0;

  always #20 pclk = ~pclk;

  brs_top #(.POWER_UP_DELAY_TIMER_LEN(PLEN)) u_brs_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg(cfg), .ana(ana), .src(src), .sleep(sleep),
    .bor_enable(bor_enable), .level_select(level_select),
    .core_reset_n(core_reset_n), .run_enable(run_enable));
  brs_supply_model u_brs_supply_model (.pclk(pclk), .vdd(vdd),
    .lvl_sel(level_select), .bor_on(bor_enable), .lp_on(cfg.lp_enable),
    .slow(slow), .ana(ana));

  // ----------------------------------------------------------------
  // expectation, comparison and bus tasks
  // ----------------------------------------------------------------
  // off mode keeps the soft enable at its reset value
  function automatic logic exp_soft(input logic [1:0] m, input logic w);
    return (m == MODE_OFF) ? SOFT_EN_RST : w;
  endfunction : exp_soft
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(pready === 1'b1) && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      complete_run();
    end
  endtask : apb
  task automatic wait_run();
    c = 0;
    while (run_enable !== 1'b1 && c < 4000) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 4000) begin
      mismatches++;
      complete_run();
    end
  endtask : wait_run
  task automatic do_reset(input brs_cfg_t k);
    @(posedge pclk);
    presetn <= 1'b0;
    cfg <= k;
    cyc(5);
    presetn <= 1'b1;
  endtask : do_reset
  // supply dip, core reset sampled at the end of the low stretch
  task automatic dip(input logic [7:0] v, input int len, input logic e);
    vdd <= v;
    cyc(len);
    check(core_reset_n, e);
    vdd <= 8'h70;
    cyc(4);
  endtask : dip

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h0000_8300));
    cyc(5);
    presetn <= 1'b1;
    apb(1'b0, ADDR_BOR_CTRL, 32'h0000_0000);
    check(rd[SOFT_EN_BIT], SOFT_EN_RST);
    apb(1'b0, ADDR_PWR_STAT, 32'h0000_0000);
    check(rd[1:0], 2'b01);
    wait_run();
    check(c >= PLEN + RELEASE_CYCLES, 1'b1);
    apb(1'b0, ADDR_BOR_CTRL, 32'h0000_0000);
    check(rd[READY_BIT], 1'b1);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check(er, 1'b1); // unmapped offset refused
    apb(1'b1, ADDR_PWR_STAT, 32'h0000_0003);
    apb(1'b0, ADDR_PWR_STAT, 32'h0000_0000);
    check(rd[1:0], 2'b11);
    for (int i = 0; i < 8; i++) dip(8'h48, 1 + $urandom % 20, 1'b1);
    dip(8'h48, 60, 1'b0);
    wait_run();
    apb(1'b0, ADDR_PWR_STAT, 32'h0000_0000);
    check(rd[BOR_FLAG_BIT], 1'b0);
    sleep <= 1'b1;
    cyc(3);
    check(bor_enable, 1'b1);
    sleep <= 1'b0;
    // awake-only mode, prompt comparator
    do_reset({MODE_NOSLEEP, 1'b0, 1'b1, 1'b0});
    slow <= 1'b0;
    wait_run();
    check(level_select, 1'b0);
    sleep <= 1'b1;
    cyc(3);
    check(bor_enable, 1'b0);
    sleep <= 1'b0;
    cyc(3);
    check(run_enable, 1'b0);
    cyc(5);
    check(core_reset_n, 1'b1);
    wait_run();
    apb(1'b0, ADDR_BOR_CTRL, 32'h0000_0000);
    check(rd[READY_BIT], 1'b1);
    // software mode: warm resets skip the timer when disabled
    do_reset({MODE_SOFT, 1'b1, 1'b1, 1'b0});
    wait_run();
    apb(1'b1, ADDR_BOR_CTRL, 32'h0000_0000);
    cyc(2);
    check(bor_enable, 1'b0);
    for (int i = 0; i < 5; i++) begin
      src[i] <= 1'b1;
      cyc(6);
      check(core_reset_n, 1'b0);
      src[i] <= 1'b0;
      wait_run();
      check(c < PLEN, 1'b1);
    end
    apb(1'b1, ADDR_BOR_CTRL, 32'h8000_0000);
    sleep <= 1'b1;
    cyc(3);
    check(bor_enable, 1'b1);
    sleep <= 1'b0;
    // off mode with the low-power monitor, timer off
    do_reset({MODE_OFF, 1'b1, 1'b0, 1'b1});
    wait_run();
    check(c < PLEN, 1'b1);
    apb(1'b1, ADDR_BOR_CTRL, 32'h0000_0000);
    apb(1'b0, ADDR_BOR_CTRL, 32'h0000_0000);
    check(rd[SOFT_EN_BIT], exp_soft(MODE_OFF, 1'b0));
    check(bor_enable, 1'b0);
    dip(8'h30, 60, 1'b0);
    wait_run();
    apb(1'b0, ADDR_PWR_STAT, 32'h0000_0000);
    check(rd[BOR_FLAG_BIT], 1'b0);
    dip(8'h10, 10, 1'b0);
    // clear pin held past the timer
    src[5] <= 1'b0;
    do_reset({MODE_OFF, 1'b0, 1'b1, 1'b0});
    cyc(150);
    check(core_reset_n, 1'b0);
    src[5] <= 1'b1;
    wait_run();
    check(c >= RELEASE_CYCLES && c < PLEN, 1'b1);
    complete_run();
  end
endmodule : brs_top_tb
`default_nettype wire

// *** logic/brs_pkg.sv ***
/*
  brs_pkg: constants, register map and carrier types for the brownout
  reset sequencer.
  assumes: apb slave with 32-bit data, 25 mhz pclk.
*/
package brs_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned POWER_UP_DELAY_TIMER_MS         = 64;
  localparam int unsigned POWER_UP_DELAY_TIMER_CYCLES     = (CLK_HZ / 1000) * POWER_UP_DELAY_TIMER_MS;
  localparam int unsigned FILTER_NS       = 1000;
  localparam int unsigned FILTER_CYCLES   =
    (FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RELEASE_CYCLES  = 10;
  localparam int unsigned CNT_W           = 21;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_BOR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_PWR_STAT   = 12'h004;

  // brownout_control_register fields
  localparam int unsigned SOFT_EN_BIT     = 31;
  localparam int unsigned READY_BIT       = 0;
  localparam logic        SOFT_EN_RST     = 1'b1;

  // power_control_status fields
  localparam int unsigned BOR_FLAG_BIT    = 0;
  localparam int unsigned POR_FLAG_BIT    = 1;

  // brownout mode encodings
  localparam logic [1:0]  MODE_OFF        = 2'b00;
  localparam logic [1:0]  MODE_SOFT       = 2'b01;
  localparam logic [1:0]  MODE_NOSLEEP    = 2'b10;
  localparam logic [1:0]  MODE_ON         = 2'b11;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode_select;   // brownout_mode_select
    logic       level_select;  // brownout_level_select
    logic       power_up_delay_timer_enable;   // power-up delay timer on
    logic       lp_enable;     // low-power brownout on
  } brs_cfg_t;

  typedef struct packed {
    logic supply_ok;       // above power-on level
    logic below_thresh;    // below brownout_threshold
    logic bor_ready;       // brownout circuit ready
    logic lp_below;        // low-power brownout trip
  } brs_analog_t;

  typedef struct packed {
    logic clear_pin_n;     // external_clear_pin, active low
    logic watchdog;
    logic reset_instr;
    logic stack_over;
    logic stack_under;
    logic prog_exit;
  } brs_src_t;

endpackage : brs_pkg

// *** logic/brs_sync.sv ***
/*
  brs_sync: two flip-flop synchroniser for a bundle of async levels.
  assumes: inputs arrive from analog blocks or pins, asynchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module brs_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             pclk,     // system clock
  input  wire logic             presetn,  // async reset, active low
  input  wire logic [WIDTH-1:0] async_i,  // raw level
  output logic      [WIDTH-1:0] sync_o    // synchronised level
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= INIT;
      sync_o <= INIT;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : brs_sync
`default_nettype wire

// *** logic/brs_top.sv ***
/*
  brs_top: brownout reset sequencer. merges reset sources, filters the
  brownout comparator, runs the power-up delay and releases core reset.
  assumes: analog monitors and pins are asynchronous; apb master on pclk.
*/
// Added by the designer: the APB register port and the address map.
// What this block does
// R1 - hold reset while supply below power-on level
// R2 - hold reset while active brownout reports low
// R3 - pass level select bit to comparator
// R4 - filter under-threshold; brownout reset clears flag
// R5 - mode 11: always active, startup waits ready
// R6 - mode 11: active in sleep, no wake delay
// R7 - forced-on modes: ready set before execution
// R8 - mode 10: active awake, startup waits ready
// R9 - mode 10: off in sleep, wake waits ready
// R10 - mode 01: soft enable bit controls detection
// R11 - mode 01: skip wait only if disabled, warm
// R12 - mode 01 disabled: run at once, ready undefined
// R13 - protection on when ready; ready readable
// R14 - soft mode: sleep leaves enable unchanged
// R15 - mode 00: always off, soft writes ignored
// R16 - any listed source asserts device reset
// R17 - optional power-up timer extends por/bor reset
// R18 - timer 64 ms, starts after por/bor release
// R19 - low-power brownout ored into brownout
// R20 - clear pin late: run ten cycles after release
// R21 - reset asserts async, releases sync
`timescale 1ns/100ps
`default_nettype none
module brs_top
  import brs_pkg::*;
#(
  parameter int unsigned POWER_UP_DELAY_TIMER_LEN = POWER_UP_DELAY_TIMER_CYCLES
) (
  input  wire logic        pclk,          // system clock, 25 mhz
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb enable
  input  wire logic        pwrite,        // apb direction
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire brs_pkg::brs_cfg_t    cfg,  // configuration word bits
  input  wire brs_pkg::brs_analog_t ana,  // analog monitor levels
  input  wire brs_pkg::brs_src_t    src,  // other reset sources
  input  wire logic        sleep,         // core is in sleep
  output logic             bor_enable,    // brownout comparator on
  output logic             level_select,  // threshold select out
  output logic             core_reset_n,  // core reset, active low
  output logic             run_enable     // core may execute
);
  import brs_pkg::*;

  // ----------------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------------
  localparam int unsigned NS = 10;
  logic [NS-1:0] raw_s, syn_s;
  logic supply_ok_s, below_s, ready_s, lp_below_s, clr_n_s;
  logic wdt_s, ri_s, sov_s, sun_s, pex_s;

  assign raw_s = {ana.supply_ok, ana.below_thresh, ana.bor_ready,
                  ana.lp_below, src.clear_pin_n, src.watchdog,
                  src.reset_instr, src.stack_over, src.stack_under,
                  src.prog_exit};

  brs_sync #(.WIDTH(NS), .INIT(10'h020)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i (raw_s),
    .sync_o  (syn_s)
  );

  assign {supply_ok_s, below_s, ready_s, lp_below_s, clr_n_s,
          wdt_s, ri_s, sov_s, sun_s, pex_s} = syn_s;

  // ----------------------------------------------------------------------
  // registers and apb slave
  // ----------------------------------------------------------------------
  logic soft_en_q;
  logic bor_flag_q;
  logic por_flag_q;
  logic wr_en, rd_en, hit;
  logic bor_evt;

  assign pready  = 1'b1;
  assign hit     = (paddr == ADDR_BOR_CTRL) || (paddr == ADDR_PWR_STAT);
  assign pslverr = psel && penable && !hit;
  assign wr_en   = psel && penable && pwrite && hit;
  assign rd_en   = psel && !penable && !pwrite;

  // soft enable keeps its value across sleep; ignored in mode 00
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_en_q <= SOFT_EN_RST;
    end else if (wr_en && paddr == ADDR_BOR_CTRL
                 && cfg.mode_select != MODE_OFF) begin // [R15] [R14]
      soft_en_q <= pwdata[SOFT_EN_BIT];                // [R10]
    end
  end

  // flags are active low; software writes 1 to rearm, event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bor_flag_q <= 1'b1;
      por_flag_q <= 1'b0;
    end else begin
      if (bor_evt) begin
        bor_flag_q <= 1'b0;                          // [R4] [R19]
      end else if (wr_en && paddr == ADDR_PWR_STAT) begin
        bor_flag_q <= pwdata[BOR_FLAG_BIT];
      end
      if (!supply_ok_s) begin
        por_flag_q <= 1'b0;
      end else if (wr_en && paddr == ADDR_PWR_STAT) begin
        por_flag_q <= pwdata[POR_FLAG_BIT];
      end
    end
  end

  // read data registered in the setup phase, valid in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= 32'h0000_0000;
      if (paddr == ADDR_BOR_CTRL) begin
        prdata[SOFT_EN_BIT] <= soft_en_q;
        prdata[READY_BIT]   <= ready_s;              // [R13]
      end else if (paddr == ADDR_PWR_STAT) begin
        prdata[BOR_FLAG_BIT] <= bor_flag_q;
        prdata[POR_FLAG_BIT] <= por_flag_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // brownout mode decode
  // ----------------------------------------------------------------------
  logic active, forced_on, wait_ready;

  always_comb begin
    active    = 1'b0;
    forced_on = 1'b0;
    case (cfg.mode_select)
      MODE_ON:      begin
        active    = 1'b1;                              // [R5] [R6]
        forced_on = 1'b1;
      end
      MODE_NOSLEEP: active = !sleep;                   // [R8] [R9]
      MODE_SOFT:    begin
        active    = soft_en_q;                         // [R10] [R14]
        forced_on = soft_en_q;
      end
      default:      active = 1'b0;                     // [R15]
    endcase
  end

  assign level_select = cfg.level_select;              // [R3]

  // ----------------------------------------------------------------------
  // brownout noise filter
  // ----------------------------------------------------------------------
  localparam logic [7:0] FILT_MAX = 8'(FILTER_CYCLES);
  logic [7:0] filt_q;
  logic       bor_trip;

  // count must exceed the filter span before a trip counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q <= 8'h00;
    end else if (active && ready_s && below_s) begin // [R13]
      if (filt_q <= FILT_MAX) begin
        filt_q <= filt_q + 8'h01;
      end
    end else begin
      filt_q <= 8'h00;
    end
  end

  assign bor_trip = (filt_q > FILT_MAX);               // [R4] [R2]
  assign bor_evt  = bor_trip || (cfg.lp_enable && lp_below_s); // [R19]

  // ----------------------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HOLD, ST_READY, ST_POWER_UP_DELAY_TIMER, ST_CLEAR, ST_TAIL, ST_RUN
  } brs_state_t;

  brs_state_t st_q;
  logic [CNT_W-1:0] cnt_q;
  logic cold_q;     // last reset came from por or brownout and run not yet reached
  logic warm_src;
  logic sleep_q;
  logic wake;

  assign warm_src = wdt_s || ri_s || sov_s || sun_s || pex_s; // [R16]
  assign wake     = sleep_q && !sleep;

  // ready is awaited when forced on, in mode 10, or after cold start in mode 01
  assign wait_ready = forced_on
                   || (cfg.mode_select == MODE_NOSLEEP)
                   || (cfg.mode_select == MODE_SOFT && cold_q); // [R11] [R12]

  // comparator follows detection; mode 01 cold wait powers it or hangs
  assign bor_enable = active                                   // [R9]
                   || (cfg.mode_select == MODE_SOFT
                       && st_q == ST_READY);                   // [R11]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep;
    end
  end

  // sequencer: por/bor restart the whole chain, others skip the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_HOLD;
      cnt_q  <= '0;
      cold_q <= 1'b1;
    end else if (!supply_ok_s || bor_evt) begin    // [R1] [R2]
      st_q   <= ST_HOLD;
      cnt_q  <= '0;
      cold_q <= 1'b1;
    end else if (warm_src) begin                   // [R16]
      st_q   <= ST_CLEAR;
      cnt_q  <= '0;
      cold_q <= 1'b0;
    end else begin
      case (st_q)
        ST_HOLD:  st_q <= ST_READY;
        ST_READY: begin
          // ready and above threshold before leaving reset
          if (!wait_ready || (ready_s && !below_s)) begin // [R5] [R8]
            cnt_q <= '0;                                  // [R18]
            if (!cold_q) begin
              // wake resumes without a core reset
              st_q <= ST_RUN;                             // [R9]
            end else begin
              st_q <= cfg.power_up_delay_timer_enable ? ST_POWER_UP_DELAY_TIMER : ST_CLEAR;
            end
          end
        end
        ST_POWER_UP_DELAY_TIMER:  begin
          if (cnt_q >= CNT_W'(POWER_UP_DELAY_TIMER_LEN - 1)) begin   // [R17] [R18]
            st_q <= ST_CLEAR;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_CLEAR: begin
          cnt_q <= '0;
          if (clr_n_s) begin
            // long-held pin: fixed tail after release
            st_q <= ST_TAIL;                          // [R20]
          end
        end
        ST_TAIL:  begin
          if (!clr_n_s) begin
            st_q  <= ST_CLEAR;                          // [R16]
          end else if (cnt_q >= CNT_W'(RELEASE_CYCLES - 1)) begin
            st_q   <= ST_RUN;                           // [R20]
            cold_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_RUN:   begin
          if (!clr_n_s) begin
            st_q <= ST_CLEAR;                           // [R16]
          end else if (wake && cfg.mode_select == MODE_NOSLEEP) begin
            st_q <= ST_READY;                           // [R9]
          end
        end
        default:  st_q <= ST_HOLD;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // reset output: async assert, sync release
  // ----------------------------------------------------------------------
  logic rst_req_n, rel_q, core_q;

  // combined request reaches flops asynchronously through the or
  assign rst_req_n = presetn && supply_ok_s && !bor_evt;

  always_ff @(posedge pclk or negedge rst_req_n) begin
    if (!rst_req_n) begin
      rel_q  <= 1'b0;                                   // [R21]
      core_q <= 1'b0;
    end else begin
      rel_q  <= (st_q == ST_RUN) || (st_q == ST_READY && !cold_q);
      core_q <= rel_q;                                  // [R21]
    end
  end

  // mode 11 wake needs no ready wait; readiness precedes run [R7] [R6]
  assign core_reset_n = core_q;
  assign run_enable   = core_q && (st_q == ST_RUN);

endmodule : brs_top
`default_nettype wire
